// File: logic/pcpd_power_down.sv
// pcpd_power_down: pin-controlled power-down sequencer with a simple
// registered user logic core whose state freezes while asleep
// assumes pins are asynchronous to core_clk and the option is fixed
// at build time through the SLEEP_ENABLE parameter
`timescale 1ns/1ns
module pcpd_power_down #(
    parameter int WIDTH = 8,
    parameter bit SLEEP_ENABLE = 1'b1,
    parameter bit FAST_GRADE = 1'b1
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // sleep pin as a two-way pin
    input wire logic sleepPinIn,
    output logic sleepPinOut,
    output logic sleepPinOe_n,
    // user logic pins
    input wire logic [WIDTH-1:0] userIn,
    input wire logic [WIDTH-1:0] userOeReq,
    output logic [WIDTH-1:0] userOut,
    output logic [WIDTH-1:0] userOe_n,
    // keeper levels seen on the input pins
    output logic [WIDTH-1:0] keeperLevel,
    // status
    output logic asleep,
    output logic outputsValid
);
    localparam int IGN_CYC = FAST_GRADE ? pcpd_pkg::IGNORE_FAST_CYC :
        pcpd_pkg::IGNORE_SLOW_CYC;
    localparam logic [pcpd_pkg::WAKE_CNT_W-1:0] WAKE_LAST =
        pcpd_pkg::WAKE_CNT_W'(pcpd_pkg::WAKE_CYC - 1);

    // elaboration checks: the wake counter must hold the whole count
    if (WIDTH < 1 || pcpd_pkg::WAKE_CYC < 1 ||
        pcpd_pkg::WAKE_CYC >= (1 << pcpd_pkg::WAKE_CNT_W))
    begin : g_bad_params
        $error("pcpd_power_down: unsupported parameters");
    end
    // sync path is two cycles, must fit the ignore window
    if (IGN_CYC < 2)
    begin : g_bad_window
        $error("pcpd_power_down: ignore window too short");
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic sleepMeta, sleepSync;
    logic [WIDTH-1:0] inMeta, inSync, oeMeta, oeSync;
    // first stage feeds only the second
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            sleepMeta <= 1'b0;
            sleepSync <= 1'b0;
            inMeta <= '0;
            inSync <= '0;
            oeMeta <= '0;
            oeSync <= '0;
        end
        else
        begin
            sleepMeta <= sleepPinIn;
            sleepSync <= sleepMeta;
            inMeta <= userIn;
            inSync <= inMeta;
            oeMeta <= userOeReq;
            oeSync <= oeMeta;
        end
    end

    // option gate: without the option the pin level is ignored
    logic sleepReq;
    assign sleepReq = SLEEP_ENABLE && sleepSync;

    // ****************************************************************
    // power-down sequencer
    // ****************************************************************
    pcpd_pkg::pcpd_state_t stateReg, stateNext;
    logic [pcpd_pkg::WAKE_CNT_W-1:0] wakeCntReg, wakeCntNext;
    logic asleepNext, validNext;

    always_comb
    begin
        stateNext = stateReg;
        wakeCntNext = wakeCntReg;
        case (stateReg)
            pcpd_pkg::RUN:
                if (sleepReq)
                    stateNext = pcpd_pkg::SLEEP;
            pcpd_pkg::SLEEP:
                if (!sleepReq)
                begin
                    stateNext = pcpd_pkg::WAKE;
                    wakeCntNext = '0;
                end
            pcpd_pkg::WAKE:
                if (sleepReq)
                    stateNext = pcpd_pkg::SLEEP;
                else if (wakeCntReg == WAKE_LAST)
                    stateNext = pcpd_pkg::RUN;
                else
                    wakeCntNext = wakeCntReg + 1'b1;
            default:
                stateNext = pcpd_pkg::RUN;
        endcase
        asleepNext = stateNext == pcpd_pkg::SLEEP;
        validNext = stateNext != pcpd_pkg::WAKE;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stateReg <= pcpd_pkg::RUN;
            wakeCntReg <= '0;
            asleep <= 1'b0;
            outputsValid <= 1'b1;
        end
        else
        begin
            stateReg <= stateNext;
            wakeCntReg <= wakeCntNext;
            asleep <= asleepNext;
            outputsValid <= validNext;
        end
    end

    // logic and holders freeze from the first synchronised sleep level,
    // no later than the end of the ignore window; they stay frozen through the wake
    logic frozen;
    assign frozen = sleepReq || stateReg != pcpd_pkg::RUN;

    // ****************************************************************
    // user logic core and input keepers
    // ****************************************************************
    logic [WIDTH-1:0] coreReg, coreNext, keepReg, keepNext;
    logic [WIDTH-1:0] oeLiveReg, oeLiveNext;
    always_comb
    begin
        // inputs are blocked while frozen; the sleep pin is not a term
        keepNext = frozen ? keepReg : inSync;
        coreNext = frozen ? coreReg : coreReg ^ keepReg;
        oeLiveNext = frozen ? oeLiveReg : oeSync;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            keepReg <= '0;
            coreReg <= '0;
            oeLiveReg <= '0;
        end
        else
        begin
            keepReg <= keepNext;
            coreReg <= coreNext;
            oeLiveReg <= oeLiveNext;
        end
    end

    // ****************************************************************
    // output holders
    // ****************************************************************
    pcpd_hold_if #(.WIDTH(WIDTH)) hold ();
    assign hold.freeze = frozen;
    assign hold.liveData = coreReg;
    assign hold.liveOe = ~oeLiveReg;

    pcpd_hold_bank #(.WIDTH(WIDTH)) u_bank (
        .core_clk(core_clk),
        .reset(reset),
        .hold(hold)
    );

    // sleep pin macrocell: buried feedback still drives it as an output
    // when the option is off and heldOe[0] is low; with the option on it stays an input
    logic pinOutNext, pinOeNext;
    always_comb
    begin
        pinOutNext = coreReg[0];
        pinOeNext = SLEEP_ENABLE ? 1'b1 : hold.heldOe[0];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            userOut <= '0;
            userOe_n <= '1;
            keeperLevel <= '0;
            sleepPinOut <= 1'b0;
            sleepPinOe_n <= 1'b1;
        end
        else
        begin
            userOut <= hold.heldData;
            userOe_n <= hold.heldOe;
            keeperLevel <= keepReg;
            sleepPinOut <= pinOutNext;
            sleepPinOe_n <= pinOeNext;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    ignore_window_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(sleepPinIn) && SLEEP_ENABLE |-> ##[1:3] frozen)
        else $error("sampling did not stop in time");
    keeper_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        asleep |=> keepReg == $past(keepReg))
        else $error("input keeper changed while asleep");
    core_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        frozen |=> coreReg == $past(coreReg))
        else $error("core state changed while frozen");
    wake_bound_a: assert property (@(posedge core_clk) disable iff (reset)
        $fell(asleep) && !asleep |-> ##[1:100] outputsValid)
        else $error("wake latency exceeded");
    no_option_a: assert property (@(posedge core_clk) disable iff (reset)
        !SLEEP_ENABLE |-> !asleep)
        else $error("slept without option");
endmodule : pcpd_power_down

// File: logic/pcpd_pkg.sv
// pcpd_pkg: shared constants for the pin-controlled power-down block
// assumes a single 100 MHz core clock and a synchronous reset
package pcpd_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    // least input-stable time before the sleep pin rises, per grade
    localparam int INPUT_STABLE_BEFORE_SLEEP_FAST_NS = 15;
    localparam int INPUT_STABLE_BEFORE_SLEEP_SLOW_NS = 20;
    // longest time after the sleep pin rises until sampling stops
    localparam int INPUT_IGNORE_AFTER_SLEEP_FAST_NS = 25;
    localparam int INPUT_IGNORE_AFTER_SLEEP_SLOW_NS = 30;
    // longest wake latency, in microseconds
    localparam int WAKE_TO_OUTPUT_VALID_US = 1;

    // longest times round down; only the ignore windows are kept at one cycle or more
    localparam int IGNORE_FAST_CYC =
        (INPUT_IGNORE_AFTER_SLEEP_FAST_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (INPUT_IGNORE_AFTER_SLEEP_FAST_NS / CLK_PERIOD_NS);
    localparam int IGNORE_SLOW_CYC =
        (INPUT_IGNORE_AFTER_SLEEP_SLOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (INPUT_IGNORE_AFTER_SLEEP_SLOW_NS / CLK_PERIOD_NS);
    localparam int WAKE_CYC =
        (WAKE_TO_OUTPUT_VALID_US * 1000) / CLK_PERIOD_NS;

    // ****************************************************************
    // states and widths
    // ****************************************************************
    localparam int WAKE_CNT_W = 8;
    typedef enum logic [1:0] {RUN, SLEEP, WAKE} pcpd_state_t;

endpackage : pcpd_pkg

// File: logic/pcpd_hold_if.sv
// pcpd_hold_if: carries data, enables and the freeze control
// between the power-down top and its hold bank
`timescale 1ns/1ns
interface pcpd_hold_if #(parameter int WIDTH = 8);
    logic freeze;
    logic [WIDTH-1:0] liveData;
    logic [WIDTH-1:0] liveOe;
    logic [WIDTH-1:0] heldData;
    logic [WIDTH-1:0] heldOe;
    modport ctrl (output freeze, liveData, liveOe, input heldData, heldOe);
    modport bank (input freeze, liveData, liveOe, output heldData, heldOe);
endinterface : pcpd_hold_if

// File: logic/pcpd_hold_bank.sv
// pcpd_hold_bank: per-bit output data and enable holders
// assumes freeze comes from the same clock domain
`timescale 1ns/1ns
module pcpd_hold_bank #(
    parameter int WIDTH = 8
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // link to controller
    pcpd_hold_if.bank hold
);
    logic [WIDTH-1:0] dataReg, dataNext, oeReg, oeNext;

    // elaboration check: at least one holder is needed
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pcpd_hold_bank: width must be at least one");
    end

    // ****************************************************************
    // holders, one per output bit
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // freeze keeps both value and enable, so a tristated pin
            // stays tristated while asleep
            always_comb
            begin
                dataNext[i] = hold.freeze ? dataReg[i] : hold.liveData[i];
                oeNext[i] = hold.freeze ? oeReg[i] : hold.liveOe[i];
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            dataReg <= '0;
            oeReg <= '1; // released: high-impedance after reset
        end
        else
        begin
            dataReg <= dataNext;
            oeReg <= oeNext;
        end
    end

    assign hold.heldData = dataReg;
    assign hold.heldOe = oeReg;

    hold_data_a: assert property (@(posedge core_clk) disable iff (reset)
        hold.freeze |=> dataReg == $past(dataReg))
        else $error("held data moved while frozen");
    hold_oe_a: assert property (@(posedge core_clk) disable iff (reset)
        hold.freeze |=> (oeReg & $past(oeReg)) == $past(oeReg))
        else $error("tristated bit driven while frozen");
endmodule : pcpd_hold_bank

// File: test/pcpd_board_model.sv
// pcpd_board_model: board logic driving the sleep pin and user inputs
// assumes one bench process calls its tasks, core_clk at 100 MHz
`timescale 1ns/1ns
module pcpd_board_model #(
    parameter int WIDTH = 8,
    parameter int STABLE_CYC = pcpd_pkg::INPUT_STABLE_BEFORE_SLEEP_SLOW_NS /
        pcpd_pkg::CLK_PERIOD_NS,
    parameter int IGNORE_CYC = pcpd_pkg::IGNORE_SLOW_CYC,
    parameter int WAKE_CYC = pcpd_pkg::WAKE_CYC
)(
    // clock
    input wire logic core_clk,
    // board-driven pins
    output logic sleepLevel,
    output logic [WIDTH-1:0] userIn,
    output logic [WIDTH-1:0] userOeReq
);
    logic scramble;
    logic [WIDTH-1:0] keepIn;
    logic [WIDTH-1:0] keepOe;

    // ****************************************************************
    // pin drive
    // ****************************************************************
    initial
    begin
        sleepLevel = 1'b0;
        scramble = 1'b0;
        keepIn = '0;
        keepOe = '0;
        userIn = '0;
        userOeReq = '0;
    end

    // flags from last cycle decide, so no race with the tasks
    always @(posedge core_clk)
    begin
        userIn <= #1 (scramble ? WIDTH'($urandom()) : keepIn);
        userOeReq <= #1 (scramble ? WIDTH'($urandom()) : keepOe);
    end

    task set_inputs(input logic [WIDTH-1:0] k, input logic [WIDTH-1:0] oe);
        @(posedge core_clk);
        #1;
        keepIn = k;
        keepOe = oe;
    endtask : set_inputs

    // one extra edge since pins follow the flags a cycle late
    task enter_sleep();
        repeat (STABLE_CYC + 1) @(posedge core_clk);
        #1;
        sleepLevel = 1'b1;
        repeat (IGNORE_CYC) @(posedge core_clk);
        #1;
        scramble = 1'b1;
    endtask : enter_sleep

    // lines stay garbage for the whole wake latency
    task leave_sleep();
        @(posedge core_clk);
        #1;
        sleepLevel = 1'b0;
        repeat (WAKE_CYC) @(posedge core_clk);
        #1;
        scramble = 1'b0;
    endtask : leave_sleep

endmodule : pcpd_board_model

// File: test/test_pin_controlled_power_down.sv
// test_pin_controlled_power_down: self-checking bench, sleep and wake
// assumes the board model above and 8-bit user pins
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    errCount++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_pin_controlled_power_down;
    typedef struct {
        logic [7:0] out; logic [7:0] oeN; logic [7:0] keep;
        logic asleep; logic valid; logic full; logic useOut;
    } pcpd_note_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sleepLevel, sleepPinOut, sleepPinOe_n, asleep, outputsValid;
    logic plainOut, plainOe_n, plainAsleep;
    logic [7:0] userIn, userOeReq, userOut, userOe_n, keeperLevel;
    int errCount = 0;
    int checks = 0;
    pcpd_note_t notes[$];
    pcpd_note_t n;
    logic [7:0] kTab [4] = '{8'h00, 8'hff, 8'h5a, 8'h00};

    // ****************************************************************
    // clock, design and board
    // ****************************************************************
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    pcpd_board_model #(.WIDTH(8)) board (.core_clk(core_clk),
        .sleepLevel(sleepLevel), .userIn(userIn), .userOeReq(userOeReq));
    // device drives its pin only when its enable is low
    pcpd_power_down #(.WIDTH(8), .SLEEP_ENABLE(1'b1)) uut (
        .core_clk(core_clk), .reset(reset),
        .sleepPinIn(!sleepPinOe_n ? sleepPinOut : sleepLevel),
        .sleepPinOut(sleepPinOut), .sleepPinOe_n(sleepPinOe_n),
        .userIn(userIn), .userOeReq(userOeReq), .userOut(userOut),
        .userOe_n(userOe_n), .keeperLevel(keeperLevel), .asleep(asleep),
        .outputsValid(outputsValid));
    // option off: the same pin must stay a plain I/O
    pcpd_power_down #(.WIDTH(8), .SLEEP_ENABLE(1'b0)) plainUut (
        .core_clk(core_clk), .reset(reset),
        .sleepPinIn(!plainOe_n ? plainOut : sleepLevel),
        .sleepPinOut(plainOut), .sleepPinOe_n(plainOe_n),
        .userIn(userIn), .userOeReq(userOeReq), .userOut(),
        .userOe_n(), .keeperLevel(), .asleep(plainAsleep),
        .outputsValid());

    // ****************************************************************
    // monitor: oldest note against the settled outputs
    // ****************************************************************
    // read at the falling edge, away from the edge that launches outputs
    always @(negedge core_clk)
    begin
        if (notes.size() > 0)
        begin
            n = notes.pop_front();
            `CHECK("asleep", n.asleep, asleep)
            `CHECK("outputsValid", n.valid, outputsValid)
            `CHECK("sleepPinOe_n", 1'b1, sleepPinOe_n)
            `CHECK("plainAsleep", 1'b0, plainAsleep)
            if (n.full)
            begin
                `CHECK("keeperLevel", n.keep, keeperLevel)
                `CHECK("userOe_n", n.oeN, userOe_n)
            end
            if (n.useOut)
            begin
                `CHECK("userOut", n.out, userOut)
                // core ran one step past the held output, xor with keeper
                `CHECK("sleepPinOut", n.out[0] ^ n.keep[0], sleepPinOut)
            end
        end
    end

    // ****************************************************************
    // driver
    // ****************************************************************
    task note(input pcpd_note_t x);
        notes.push_back(x);
        @(posedge core_clk);
        #1;
    endtask : note

    task wait_for(input int lim, input logic wantAsleep, input logic wantV);
        int i;
        i = 0;
        while ((asleep !== wantAsleep || outputsValid !== wantV) && i < lim)
        begin
            @(posedge core_clk);
            #1;
            i++;
        end
    endtask : wait_for

    // sleep with garbage inputs, then wake and resume sampling
    task sleep_round(input logic [7:0] k, input logic [7:0] oe);
        logic [7:0] held;
        board.set_inputs(k, oe);
        board.enter_sleep();
        wait_for(8, 1'b1, 1'b1);
        held = userOut;
        repeat (20) note('{held, ~oe, k, 1'b1, 1'b1, 1'b1, 1'b1});
        fork
            board.leave_sleep();
            begin
                wait_for(8, 1'b0, 1'b0);
                note('{held, ~oe, k, 1'b0, 1'b0, 1'b1, 1'b1});
                wait_for(110, 1'b0, 1'b1);
                note('{held, ~oe, k, 1'b0, 1'b1, 1'b0, 1'b0});
            end
        join
        board.set_inputs(~k, k);
        repeat (6) @(posedge core_clk);
        #1;
        note('{held, ~k, ~k, 1'b0, 1'b1, 1'b1, 1'b0});
    endtask : sleep_round

    task end_sim();
        if (errCount == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    initial
    begin
        void'($urandom(32'h1c1d0648));
        repeat (10) @(posedge core_clk);
        #1;
        reset = 1'b0;
        note('{8'h00, 8'hff, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1});
        kTab[3] = 8'($urandom());
        foreach (kTab[i])
            sleep_round(kTab[i], 8'($urandom()));
        repeat (3) @(posedge core_clk);
        end_sim();
    end

    // watchdog: four rounds need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        errCount++;
        end_sim();
    end
endmodule : test_pin_controlled_power_down
